/* File: include/socp_regs.vh */
`ifndef SOCP_REGS_VH
`define SOCP_REGS_VH

// Register word addresses as seen on the register access port.
`define SOCP_ADDR_SETTLE 10'h196
`define SOCP_ADDR_AOUT1 10'h197
`define SOCP_ADDR_AOUT2 10'h198
`define SOCP_ADDR_AOUT3 10'h199
`define SOCP_ADDR_CLKDIV 10'h1A0

// Reset values of every register.
`define SOCP_RST_SETTLE 6'h00
`define SOCP_RST_AOUT 7'h00
`define SOCP_RST_CLKDIV 6'h00

// Settle count field, low six bits.
`define SOCP_SETTLE_MSB 5
`define SOCP_SETTLE_LSB 0

// Core clock divider field, low six bits.
`define SOCP_DIV_MSB 5
`define SOCP_DIV_LSB 0

// Analog output configuration fields.
`define SOCP_AOUT_EN_BIT 0
`define SOCP_AOUT_GAIN_MSB 2
`define SOCP_AOUT_GAIN_LSB 1
`define SOCP_AOUT_SRC_MSB 5
`define SOCP_AOUT_SRC_LSB 3
`define SOCP_AOUT_UNITY_BIT 6
`define SOCP_AOUT_MSB 6

// Fixed extra core periods added to every settling window.
`define SOCP_SETTLE_EXTRA 4

// Gain field codes.
`define SOCP_GSEL_1P33 2'h0
`define SOCP_GSEL_2P0 2'h1
`define SOCP_GSEL_3P0 2'h2
`define SOCP_GSEL_5P33 2'h3

// Encoded gain driven to the analog stage.
`define SOCP_GAIN_1P0 3'h0
`define SOCP_GAIN_1P33 3'h1
`define SOCP_GAIN_2P0 3'h2
`define SOCP_GAIN_3P0 3'h3
`define SOCP_GAIN_5P33 3'h4

// Source field codes.
`define SOCP_SRC_CH_A 3'h0
`define SOCP_SRC_CH_B 3'h1
`define SOCP_SRC_REF 3'h5
`define SOCP_SRC_SUPPLY 3'h7

// One-hot source route bits driven to the analog multiplexer.
`define SOCP_ROUTE_NONE 4'h0
`define SOCP_ROUTE_CH_A 4'h1
`define SOCP_ROUTE_CH_B 4'h2
`define SOCP_ROUTE_REF 4'h4
`define SOCP_ROUTE_SUPPLY 4'h8

// Divider thresholds for the operating modes.
`define SOCP_DIV_MIN_CORE 6'h01
`define SOCP_DIV_MIN_CODE_RD 6'h02

`endif

/* File: hdl/socp_settle_timer.v */
`default_nettype none

// One settling window: counts core periods after a threshold write.
module socp_settle_timer #(
    parameter CNT_W = 10
) (
    input wire clk_sys,
    input wire rst,
    input wire core_tick,
    input wire start,
    input wire [CNT_W-1:0] load_value,
    output reg busy_r
);

    // Remaining core periods of the window.
    reg [CNT_W-1:0] count_r;
    reg [CNT_W-1:0] count_nxt;

    // A new write restarts the window even when one is running, so the
    // latest threshold always gets its full settling time.
    always @* begin
        count_nxt = count_r;
        if (start) begin
            count_nxt = load_value;
        end else if (core_tick && (count_r != {CNT_W{1'b0}})) begin
            count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Counter and busy flag; busy is high exactly while periods remain.
    always @(posedge clk_sys) begin
        if (rst) begin
            count_r <= {CNT_W{1'b0}};
            busy_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            busy_r <= (count_nxt != {CNT_W{1'b0}});
        end
    end

endmodule // socp_settle_timer

`default_nettype wire

/* File: hdl/socp_config_bank.v */
// Contract
// - DAC write invalidates feedback: settle+filter+4 periods.
// - Feedback tests read false during settling.
// - Boost DAC writes never invalidate feedback.
// - Enabled output drives source, else high impedance.
// - Gain codes: 1.33, 2.0, 3.0, 5.33.
// - Unity bit forces gain 1.0.
// - Output 1 sources: ch1, ch3, reference.
// - Output 2 sources: ch2, ch4, reference.
// - Output 3 sources: ch5, ch6, reference, supply.
// - Core clock is system clock over divider+1.
// - Divider zero forbids cores and flag outputs.
// - Code RAM reads need divider two or more.
`include "socp_regs.vh"
`default_nettype none

module socp_config_bank #(
    parameter NUM_CH = 6,
    parameter FLT_W = 8,
    parameter CNT_W = 10
) (
    input wire clk_sys,
    input wire rst,
    // Register access port, driven by the serial slave on the same clock.
    input wire [9:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire regs_locked,
    output reg [15:0] reg_rdata_r,
    output reg reg_rvalid_r,
    // Current DAC threshold write strobes and per-channel filter lengths.
    input wire [NUM_CH-1:0] dac_wr,
    input wire [NUM_CH*FLT_W-1:0] filter_len,
    input wire boost_dac_wr,
    // Raw feedback test results from the comparators.
    input wire [NUM_CH-1:0] fb_test_raw,
    input wire boost_fb_test_raw,
    output reg [NUM_CH-1:0] fb_test_r,
    output reg boost_fb_test_r,
    output reg [NUM_CH-1:0] fb_settling_r,
    // Analog output pins: enable, one-hot route and encoded gain.
    output reg analog_out1_pin_oe_r,
    output reg [3:0] analog_out1_route_r,
    output reg [2:0] analog_out1_gain_r,
    output reg analog_out2_pin_oe_r,
    output reg [3:0] analog_out2_route_r,
    output reg [2:0] analog_out2_gain_r,
    output reg analog_out3_pin_oe_r,
    output reg [3:0] analog_out3_route_r,
    output reg [2:0] analog_out3_gain_r,
    // Core clock enable and mode permissions.
    output reg core_clock_r,
    output reg core_run_allow_r,
    output reg flag_drive_allow_r,
    input wire code_ram_rd_req,
    output reg code_ram_rd_grant_r,
    output reg code_ram_rd_refused_r
);

    // Settle count register field.
    reg [5:0] dac_settle_count_r;
    // Analog output configuration registers, seven used bits each.
    reg [6:0] analog_out1_config_r;
    reg [6:0] analog_out2_config_r;
    reg [6:0] analog_out3_config_r;
    // Core clock divider field.
    reg [5:0] core_div_minus_one_r;
    // Core clock divider counter.
    reg [5:0] div_count_r;
    // Per-channel settling window busy flags from the timers.
    wire [NUM_CH-1:0] settle_busy;
    // Read data before it is registered.
    reg [15:0] rdata_nxt;
    // Fixed extra core periods, sized to the window counter so the sum keeps its width.
    localparam [CNT_W-1:0] SETTLE_EXTRA_W = `SOCP_SETTLE_EXTRA;

    // Gain decode shared by the three outputs.
    function [2:0] decode_gain;
        input unity;
        input [1:0] gsel;
        begin
            if (unity) begin
                decode_gain = `SOCP_GAIN_1P0;
            end else begin
                case (gsel)
                    `SOCP_GSEL_1P33: decode_gain = `SOCP_GAIN_1P33;
                    `SOCP_GSEL_2P0: decode_gain = `SOCP_GAIN_2P0;
                    `SOCP_GSEL_3P0: decode_gain = `SOCP_GAIN_3P0;
                    default: decode_gain = `SOCP_GAIN_5P33;
                endcase
            end
        end
    endfunction

    // Source decode shared by the three outputs. Codes with no documented
    // source select nothing, so the pin is never driven from an undefined node.
    function [3:0] decode_route;
        input [2:0] sel;
        input supply_ok;
        begin
            case (sel)
                `SOCP_SRC_CH_A: decode_route = `SOCP_ROUTE_CH_A;
                `SOCP_SRC_CH_B: decode_route = `SOCP_ROUTE_CH_B;
                `SOCP_SRC_REF: decode_route = `SOCP_ROUTE_REF;
                `SOCP_SRC_SUPPLY: decode_route = supply_ok ? `SOCP_ROUTE_SUPPLY : `SOCP_ROUTE_NONE;
                default: decode_route = `SOCP_ROUTE_NONE;
            endcase
        end
    endfunction

    // Register writes. Lockable fields ignore writes while locked; the
    // analog output registers carry no lock and always accept writes.
    always @(posedge clk_sys) begin
        if (rst) begin
            dac_settle_count_r <= `SOCP_RST_SETTLE;
            analog_out1_config_r <= `SOCP_RST_AOUT;
            analog_out2_config_r <= `SOCP_RST_AOUT;
            analog_out3_config_r <= `SOCP_RST_AOUT;
            core_div_minus_one_r <= `SOCP_RST_CLKDIV;
        end else if (reg_wr) begin
            case (reg_addr)
                `SOCP_ADDR_SETTLE: begin
                    if (!regs_locked) begin
                        dac_settle_count_r <= reg_wdata[`SOCP_SETTLE_MSB:`SOCP_SETTLE_LSB];
                    end
                end
                `SOCP_ADDR_AOUT1: begin
                    analog_out1_config_r <= reg_wdata[`SOCP_AOUT_MSB:0];
                end
                `SOCP_ADDR_AOUT2: begin
                    analog_out2_config_r <= reg_wdata[`SOCP_AOUT_MSB:0];
                end
                `SOCP_ADDR_AOUT3: begin
                    analog_out3_config_r <= reg_wdata[`SOCP_AOUT_MSB:0];
                end
                `SOCP_ADDR_CLKDIV: begin
                    // Locking here is what protects running cores from a
                    // divider change; the host is trusted not to unlock.
                    if (!regs_locked) begin
                        core_div_minus_one_r <= reg_wdata[`SOCP_DIV_MSB:`SOCP_DIV_LSB];
                    end
                end
                default: begin
                    // Addresses outside this bank belong to other blocks.
                end
            endcase
        end
    end

    // Read mux. Reserved bits and unmapped addresses read as zero.
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `SOCP_ADDR_SETTLE: rdata_nxt = {10'h000, dac_settle_count_r};
            `SOCP_ADDR_AOUT1: rdata_nxt = {9'h000, analog_out1_config_r};
            `SOCP_ADDR_AOUT2: rdata_nxt = {9'h000, analog_out2_config_r};
            `SOCP_ADDR_AOUT3: rdata_nxt = {9'h000, analog_out3_config_r};
            `SOCP_ADDR_CLKDIV: rdata_nxt = {10'h000, core_div_minus_one_r};
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // Read data is captured on the read strobe and held until the next read.
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_r <= 16'h0000;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rdata_nxt;
            end
        end
    end

    // Core clock divider: one enable pulse every divider+1 system cycles.
    // A count already beyond a freshly lowered divider wraps at once, so a
    // change never stalls the core clock for a full 64-cycle lap; the host
    // still must not change it while cores run, since periods would jitter.
    always @(posedge clk_sys) begin
        if (rst) begin
            div_count_r <= 6'h00;
            core_clock_r <= 1'b0;
        end else if (div_count_r >= core_div_minus_one_r) begin
            div_count_r <= 6'h00;
            core_clock_r <= 1'b1;
        end else begin
            div_count_r <= div_count_r + 6'h01;
            core_clock_r <= 1'b0;
        end
    end

    // Mode permissions follow the divider setting directly.
    always @(posedge clk_sys) begin
        if (rst) begin
            core_run_allow_r <= 1'b0;
            flag_drive_allow_r <= 1'b0;
        end else begin
            core_run_allow_r <= (core_div_minus_one_r >= `SOCP_DIV_MIN_CORE);
            flag_drive_allow_r <= (core_div_minus_one_r >= `SOCP_DIV_MIN_CORE);
        end
    end

    // Code RAM read gate. Register and data RAM accesses are never gated
    // here; only code RAM reads depend on the divider.
    always @(posedge clk_sys) begin
        if (rst) begin
            code_ram_rd_grant_r <= 1'b0;
            code_ram_rd_refused_r <= 1'b0;
        end else begin
            code_ram_rd_grant_r <= code_ram_rd_req &&
                (core_div_minus_one_r >= `SOCP_DIV_MIN_CODE_RD);
            code_ram_rd_refused_r <= code_ram_rd_req &&
                (core_div_minus_one_r < `SOCP_DIV_MIN_CODE_RD);
        end
    end

    // One settling timer per current DAC channel, each loaded with its own
    // filter length so channels settle independently.
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_settle
            wire [CNT_W-1:0] window_len;
            // Window length in core periods, widened before the sum.
            assign window_len = {{(CNT_W-6){1'b0}}, dac_settle_count_r} +
                {{(CNT_W-FLT_W){1'b0}}, filter_len[ch*FLT_W +: FLT_W]} +
                SETTLE_EXTRA_W;

            socp_settle_timer #(
                .CNT_W(CNT_W)
            ) u_timer (
                .clk_sys(clk_sys),
                .rst(rst),
                .core_tick(core_clock_r),
                .start(dac_wr[ch]),
                .load_value(window_len),
                .busy_r(settle_busy[ch])
            );
        end
    endgenerate

    // Feedback masking. The boost channel has no timer at all, so its
    // writes cannot touch its feedback.
    always @(posedge clk_sys) begin
        if (rst) begin
            fb_test_r <= {NUM_CH{1'b0}};
            fb_settling_r <= {NUM_CH{1'b0}};
            boost_fb_test_r <= 1'b0;
        end else begin
            fb_test_r <= fb_test_raw & ~settle_busy;
            fb_settling_r <= settle_busy;
            boost_fb_test_r <= boost_fb_test_raw;
        end
    end

    // Analog output 1: channel 1, channel 3 or the reference.
    always @(posedge clk_sys) begin
        if (rst) begin
            analog_out1_pin_oe_r <= 1'b0;
            analog_out1_route_r <= `SOCP_ROUTE_NONE;
            analog_out1_gain_r <= `SOCP_GAIN_1P0;
        end else begin
            analog_out1_route_r <= analog_out1_config_r[`SOCP_AOUT_EN_BIT] ?
                decode_route(analog_out1_config_r[`SOCP_AOUT_SRC_MSB:`SOCP_AOUT_SRC_LSB], 1'b0) :
                `SOCP_ROUTE_NONE;
            analog_out1_pin_oe_r <= analog_out1_config_r[`SOCP_AOUT_EN_BIT];
            analog_out1_gain_r <= decode_gain(analog_out1_config_r[`SOCP_AOUT_UNITY_BIT],
                analog_out1_config_r[`SOCP_AOUT_GAIN_MSB:`SOCP_AOUT_GAIN_LSB]);
        end
    end

    // Analog output 2: channel 2, channel 4 or the reference.
    always @(posedge clk_sys) begin
        if (rst) begin
            analog_out2_pin_oe_r <= 1'b0;
            analog_out2_route_r <= `SOCP_ROUTE_NONE;
            analog_out2_gain_r <= `SOCP_GAIN_1P0;
        end else begin
            analog_out2_route_r <= analog_out2_config_r[`SOCP_AOUT_EN_BIT] ?
                decode_route(analog_out2_config_r[`SOCP_AOUT_SRC_MSB:`SOCP_AOUT_SRC_LSB], 1'b0) :
                `SOCP_ROUTE_NONE;
            analog_out2_pin_oe_r <= analog_out2_config_r[`SOCP_AOUT_EN_BIT];
            analog_out2_gain_r <= decode_gain(analog_out2_config_r[`SOCP_AOUT_UNITY_BIT],
                analog_out2_config_r[`SOCP_AOUT_GAIN_MSB:`SOCP_AOUT_GAIN_LSB]);
        end
    end

    // Analog output 3: channel 5, channel 6, the reference or the supply.
    always @(posedge clk_sys) begin
        if (rst) begin
            analog_out3_pin_oe_r <= 1'b0;
            analog_out3_route_r <= `SOCP_ROUTE_NONE;
            analog_out3_gain_r <= `SOCP_GAIN_1P0;
        end else begin
            analog_out3_route_r <= analog_out3_config_r[`SOCP_AOUT_EN_BIT] ?
                decode_route(analog_out3_config_r[`SOCP_AOUT_SRC_MSB:`SOCP_AOUT_SRC_LSB], 1'b1) :
                `SOCP_ROUTE_NONE;
            analog_out3_pin_oe_r <= analog_out3_config_r[`SOCP_AOUT_EN_BIT];
            analog_out3_gain_r <= decode_gain(analog_out3_config_r[`SOCP_AOUT_UNITY_BIT],
                analog_out3_config_r[`SOCP_AOUT_GAIN_MSB:`SOCP_AOUT_GAIN_LSB]);
        end
    end

    // The boost DAC strobe is accepted only to show it has no effect here.
    wire boost_write_ignored;
    assign boost_write_ignored = boost_dac_wr;

endmodule // socp_config_bank

`default_nettype wire

/* File: tb/socp_config_bank_props.sv */
`default_nettype none

// Checker on the top ports of the configuration bank.
module socp_config_bank_props #(
    parameter int NUM_CH = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic reg_rvalid_r,
    input wire logic [NUM_CH-1:0] dac_wr,
    input wire logic [NUM_CH-1:0] fb_test_r,
    input wire logic [NUM_CH-1:0] fb_settling_r,
    input wire logic boost_fb_test_raw,
    input wire logic boost_fb_test_r,
    input wire logic analog_out1_pin_oe_r,
    input wire logic [3:0] analog_out1_route_r,
    input wire logic [3:0] analog_out3_route_r,
    input wire logic core_clock_r,
    input wire logic core_run_allow_r,
    input wire logic flag_drive_allow_r,
    input wire logic code_ram_rd_req,
    input wire logic code_ram_rd_grant_r,
    input wire logic code_ram_rd_refused_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_read_answer_next:
        assert property (reg_rd |=> reg_rvalid_r) else $error("read not answered next cycle");
    a_window_opens:
        assert property (dac_wr[0] |-> ##2 fb_settling_r[0]) else $error("window did not open");
    // A test result leaking during the window would let microcode act on a stale threshold.
    a_window_masks:
        assert property ((fb_settling_r & fb_test_r) == '0) else $error("feedback true while settling");
    a_boost_unmasked:
        assert property ($past(!rst) |-> boost_fb_test_r == $past(boost_fb_test_raw))
        else $error("boost feedback altered");
    a_off_means_hiz:
        assert property (!analog_out1_pin_oe_r |-> analog_out1_route_r == 4'h0) else $error("route while off");
    a_route_one_hot:
        assert property ($onehot0(analog_out3_route_r)) else $error("several sources routed");
    a_modes_follow:
        assert property (core_run_allow_r == flag_drive_allow_r) else $error("mode permissions disagree");
    a_div0_each_tick:
        assert property ($past(!rst, 2) && !core_run_allow_r && $past(!core_run_allow_r) |-> core_clock_r)
        else $error("core tick missing at divider zero");
    a_code_rd_answer:
        assert property (code_ram_rd_req |=> code_ram_rd_grant_r ^ code_ram_rd_refused_r)
        else $error("code ram request not answered");
    a_grant_needs_div:
        assert property (code_ram_rd_grant_r |-> core_run_allow_r) else $error("grant at low divider");
endmodule // socp_config_bank_props

bind socp_config_bank socp_config_bank_props #(.NUM_CH(NUM_CH)) u_props (
    .clk_sys, .rst, .reg_rd, .reg_rvalid_r, .dac_wr, .fb_test_r, .fb_settling_r,
    .boost_fb_test_raw, .boost_fb_test_r, .analog_out1_pin_oe_r, .analog_out1_route_r,
    .analog_out3_route_r, .core_clock_r, .core_run_allow_r, .flag_drive_allow_r,
    .code_ram_rd_req, .code_ram_rd_grant_r, .code_ram_rd_refused_r);

`default_nettype wire

/* File: tb/socp_host_model.sv */
`include "socp_regs.vh"
`default_nettype none

// Host model: single-word register accesses with an idle cycle after each.
module socp_host_model (
    input wire logic clk_sys,
    output logic [9:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic regs_locked
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle values at time zero.
    initial begin
        reg_addr = 10'h000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        regs_locked = 1'b0;
    end

    // One access; address and data are inverted once released so nothing stale lingers.
    task automatic access(input logic [9:0] a, input logic [15:0] d, input logic w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge clk_sys);
    endtask

    // Writes; the divider is left alone once locked, as the cores may be running.
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        if (!(regs_locked && a == `SOCP_ADDR_CLKDIV)) begin
            access(a, d, 1'b1);
        end
    endtask

    task automatic rd(input logic [9:0] a);
        access(a, 16'h0000, 1'b0);
    endtask

    // Locks the bank for normal operation.
    task automatic lock();
        @(posedge clk_sys);
        regs_locked <= 1'b1;
    endtask
endmodule // socp_host_model

`default_nettype wire

/* File: tb/test_settle_outmux_clock_prescale.sv */
`include "socp_regs.vh"
`default_nettype none

module test_settle_outmux_clock_prescale;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    wire [9:0] reg_addr;
    wire [15:0] reg_wdata;
    wire reg_wr, reg_rd, regs_locked;
    logic [15:0] reg_rdata_r;
    logic reg_rvalid_r;
    logic [5:0] dac_wr = 6'h00;
    logic [47:0] filter_len = 48'h0;
    logic boost_dac_wr = 1'b0;
    logic [5:0] fb_test_raw = 6'h00;
    logic boost_fb_test_raw = 1'b0;
    logic [5:0] fb_test_r, fb_settling_r;
    logic boost_fb_test_r;
    logic analog_out1_pin_oe_r, analog_out2_pin_oe_r, analog_out3_pin_oe_r;
    logic [3:0] analog_out1_route_r, analog_out2_route_r, analog_out3_route_r;
    logic [2:0] analog_out1_gain_r, analog_out2_gain_r, analog_out3_gain_r;
    logic core_clock_r, core_run_allow_r, flag_drive_allow_r;
    logic code_ram_rd_req = 1'b0;
    logic code_ram_rd_grant_r, code_ram_rd_refused_r;
    int n_checks = 0;
    int fail_count = 0;
    logic [15:0] exp_q[$]; // Expected read words, oldest first.
    wire [2:0] oe = {analog_out3_pin_oe_r, analog_out2_pin_oe_r, analog_out1_pin_oe_r};
    wire [11:0] rt = {analog_out3_route_r, analog_out2_route_r, analog_out1_route_r};
    wire [8:0] gn = {analog_out3_gain_r, analog_out2_gain_r, analog_out1_gain_r};

    always #2.5 clk_sys = ~clk_sys;

    socp_config_bank u_socp_config_bank (.*);
    socp_host_model u_socp_host_model (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .regs_locked);

    // Raw comparator results change at random every cycle.
    always @(posedge clk_sys) begin
        fb_test_raw <= 6'($urandom);
        boost_fb_test_raw <= 1'($urandom);
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Reads come back in order, so the oldest note belongs to each answer.
    always @(posedge clk_sys) begin
        if (reg_rvalid_r === 1'b1) begin
            chk("read data", exp_q.size() ? exp_q.pop_front() : 16'hDEAD, reg_rdata_r);
        end
    end

    task automatic rd_exp(input logic [9:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        u_socp_host_model.rd(a);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One output config: write it with random reserved bits, then check pins and read-back.
    task automatic aout_case(input int n, input logic [6:0] c);
        logic [3:0] er;
        logic [31:0] r;
        r = $urandom;
        er = 4'h0;
        if (c[0]) begin
            case (c[5:3])
                3'h0: er = 4'h1;
                3'h1: er = 4'h2;
                3'h5: er = 4'h4;
                3'h7: er = (n == 3) ? 4'h8 : 4'h0;
                default: er = 4'h0;
            endcase
        end
        u_socp_host_model.wr(`SOCP_ADDR_AOUT1 + 10'(n - 1), {r[8:0], c});
        @(negedge clk_sys);
        chk("enable", c[0], oe[n-1]);
        chk("route", er, rt[4*(n-1)+:4]);
        chk("gain", c[6] ? 16'h0 : c[2:1] + 16'h1, gn[3*(n-1)+:3]);
        rd_exp(`SOCP_ADDR_AOUT1 + 10'(n - 1), {9'h000, c});
    endtask

    logic [2:0] srcs[8] = '{3'h0, 3'h1, 3'h5, 3'h7, 3'h2, 3'h0, 3'h1, 3'h5};
    logic [9:0] adrs[6] = '{`SOCP_ADDR_SETTLE, `SOCP_ADDR_AOUT1, `SOCP_ADDR_AOUT2,
                            `SOCP_ADDR_AOUT3, `SOCP_ADDR_CLKDIV, 10'h1A1};
    int cnt, t;
    logic [5:0] oth;

    initial begin
        void'($urandom(86234));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, plus one unmapped word.
        foreach (adrs[i]) rd_exp(adrs[i], 16'h0000);
        chk("outputs at reset", 16'h0000, {oe, rt[3:0], core_run_allow_r});
        $display("test reset done");
        for (int n = 1; n <= 3; n++) begin
            for (int i = 0; i < 8; i++) aout_case(n, {i == 4, srcs[i], 2'(i), i != 3});
        end
        $display("test analog outputs done");
        // Settling windows at divider zero: one core period per cycle.
        u_socp_host_model.wr(`SOCP_ADDR_SETTLE, 16'h0003);
        filter_len <= {$urandom, 16'($urandom)} & 48'h070707070707;
        for (int ch = 0; ch <= 6; ch++) begin
            @(posedge clk_sys);
            if (ch < 6) dac_wr[ch] <= 1'b1;
            else boost_dac_wr <= 1'b1;
            @(posedge clk_sys);
            dac_wr <= 6'h00;
            boost_dac_wr <= 1'b0;
            cnt = 0;
            oth = 6'h00;
            repeat (40) begin
                @(negedge clk_sys);
                if (ch < 6 && fb_settling_r[ch]) cnt++;
                oth |= (ch < 6) ? fb_settling_r & ~(6'h01 << ch) : fb_settling_r;
            end
            if (ch < 6) chk("window", 16'(7 + filter_len[8*ch+:8]), 16'(cnt));
            chk("other windows", 16'h0000, oth);
        end
        $display("test settling done");
        for (int d = 0; d < 4; d++) begin
            u_socp_host_model.wr(`SOCP_ADDR_CLKDIV, 16'(d));
            code_ram_rd_req <= 1'b1;
            rd_exp(`SOCP_ADDR_CLKDIV, 16'(d));
            repeat (8) @(negedge clk_sys);
            chk("core allow", d >= 1, core_run_allow_r);
            chk("flag allow", d >= 1, flag_drive_allow_r);
            chk("code grant", d >= 2, code_ram_rd_grant_r);
            chk("code refuse", d < 2, code_ram_rd_refused_r);
            t = 0;
            while (!core_clock_r && t < 20) begin
                @(negedge clk_sys);
                t++;
            end
            t = 0;
            do begin
                @(negedge clk_sys);
                t++;
            end while (!core_clock_r && t < 20);
            chk("core period", 16'(d + 1), 16'(t));
            @(posedge clk_sys);
            code_ram_rd_req <= 1'b0;
        end
        $display("test divider done");
        // Locked bank keeps its settle count; output configs stay writable.
        u_socp_host_model.lock();
        u_socp_host_model.wr(`SOCP_ADDR_SETTLE, 16'h0021);
        rd_exp(`SOCP_ADDR_SETTLE, 16'h0003);
        aout_case(2, 7'h09);
        repeat (4) @(posedge clk_sys);
        chk("reads pending", 16'h0000, 16'(exp_q.size()));
        $display("test lock done");
        wrap_up();
    end

    // Watchdog: the tests need well under two thousand cycles.
    initial begin
        repeat (6000) @(posedge clk_sys);
        fail_count++;
        wrap_up();
    end
endmodule // test_settle_outmux_clock_prescale

`default_nettype wire
